// [hw/sram_host_consts.svh]
// timing constants and pin widths for the async sram host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS       10
`define ADDR_W              19
`define DATA_W              16
`define READ_CYCLE_TIME_NS  45
`define ADDR_TO_DATA_NS     45
`define OUT_GATE_TO_DATA_NS 22
`define WRITE_DATA_SETUP_NS 25
`define WRITE_PULSE_NS      35
`define WRITE_CYCLE_TIME_NS 45
`define WRITE_TO_FLOAT_NS   18
`define DRIVE_RELEASE_NS    18
`define RETENTION_RECOVERY_NS 45
`define CEIL_CYC(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [hw/sram_host_pkg.sv]
// types for the async sram host controller
package sram_host_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} op_e;
  typedef logic [7:0] count_t;
endpackage

// [hw/sram_host.sv]
// host controller driving a 512k x 16 asynchronous static memory
// Function
// RULE1 - write happens only with select, strobe, byte low
// RULE2 - first released enable ends the write
// RULE3 - data stable 25 ns before write end
// RULE4 - address stable from start, 35 ns before end
// RULE5 - strobe, select, bytes low 35 ns minimum
// RULE6 - read data valid 45 ns; cycles 45 ns apart
// RULE7 - old read data holds 10 ns after address
// RULE8 - data valid 22 ns after output gate
// RULE9 - data valid 45 ns after select falls
// RULE10 - data floats within 18 ns of release
// RULE11 - data drive starts 5 or 10 ns late
// RULE12 - turn-off always faster than turn-on
// RULE13 - host never drives while memory may drive
// RULE14 - select rising with strobe high keeps float
// RULE15 - strobe pulse covers setup plus float time
// RULE16 - deselected when select high or both bytes high
// RULE17 - standby after deselect, instant power up
// RULE18 - deselect before supply drop, 45 ns recovery
// RULE19 - strobe high throughout every read
// RULE20 - address valid before select falls on reads; here set on the same edge as select
// RULE21 - 19-bit word address, bytes gate halves
`include "sram_host_consts.svh"

// timing budget at a 10 ns clock, in cycles after the taking edge:
// read:  select, gate and bytes fall at 0; the word reaches the pins by 4.5
//        and clears the synchroniser by 6; sampled and released at 8
// write: select, strobe and bytes fall at 0; data driven from 3, after the
//        memory has had 18 ns to float; strobe rises at 8 and ends the write
// a read is back in idle at 11 and a write at 14, well past the cycle time
// every count is rounded up, so each phase is at least its nanosecond figure
module sram_host
  import sram_host_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  input  wire logic              CLOCK,       // 100 mhz system clock
  input  wire logic              RSTN,        // synchronous reset, active low
  input  wire logic              REQ_VALID,   // request strobe from user
  input  wire logic              REQ_WRITE,   // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] REQ_ADDR,    // word address
  input  wire logic [DATA_W-1:0] REQ_WDATA,   // write data
  input  wire logic [1:0]        REQ_BYTE_EN, // bit1 upper, bit0 lower, active high
  input  wire logic              RETAIN_REQ,  // ask for data-retention entry
  output logic                   REQ_READY,   // idle, request may be taken
  output logic                   RSP_VALID,   // one-cycle read data pulse
  output logic [DATA_W-1:0]      RSP_RDATA,   // captured read data
  output logic                   RETAIN_OK,   // memory deselected, supply may drop
  output logic [ADDR_W-1:0]      MEM_ADDR,    // address pins
  output logic                   MEM_SEL_N,   // chip enable, active low
  output logic                   MEM_WSTB_N,  // write strobe, active low
  output logic                   MEM_OGATE_N, // output enable, active low
  output logic                   UPPER_BYTE_SEL_N, // upper byte enable
  output logic                   LOWER_BYTE_SEL_N, // lower byte enable
  input  wire logic [DATA_W-1:0] MEM_DQ_I,    // data pins, input side
  output logic [DATA_W-1:0]      MEM_DQ_O,    // data pins, output side
  output logic                   MEM_DQ_OE    // high while host drives data
);
  import sram_host_pkg::*;

  // phase lengths in cycles, rounded up
  localparam count_t RD_CYC  = count_t'(`CEIL_CYC(`ADDR_TO_DATA_NS) + 2); // + sync delay
  localparam count_t FLT_CYC = count_t'(`CEIL_CYC(`WRITE_TO_FLOAT_NS));
  localparam count_t WP_CYC  = count_t'(`CEIL_CYC(`WRITE_PULSE_NS));
  localparam count_t WSU_CYC = count_t'(`CEIL_CYC(`WRITE_DATA_SETUP_NS));
  localparam count_t GAP_CYC = count_t'(`CEIL_CYC(`WRITE_CYCLE_TIME_NS));
  localparam count_t REC_CYC = count_t'(`CEIL_CYC(`RETENTION_RECOVERY_NS));

  // a phase ends on the edge at which its counter has run down to zero
  function automatic logic phase_done(input count_t left);
    return left == 8'h00;
  endfunction

  typedef enum logic [2:0] {S_IDLE, S_READ, S_WFLOAT, S_WPULSE, S_GAP, S_RETAIN, S_RECOVER}
    state_e;

  state_e state_reg;                   // controller phase
  count_t cnt_reg;                     // cycles left in phase
  logic [DATA_W-1:0] dq_meta_reg;      // first sync stage, read only by second
  logic [DATA_W-1:0] dq_sync_reg;      // synchronised data pins

  // two-flop synchroniser on the data pins
  always_ff @(posedge CLOCK) begin
    dq_meta_reg <= MEM_DQ_I;
    dq_sync_reg <= dq_meta_reg;
  end

  // main sequencer: strobes, address and counters
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      state_reg        <= S_IDLE;
      cnt_reg          <= 8'h00;
      MEM_ADDR         <= '0;
      MEM_SEL_N        <= 1'b1;           // deselected out of reset [RULE16]
      MEM_WSTB_N       <= 1'b1;
      MEM_OGATE_N      <= 1'b1;
      UPPER_BYTE_SEL_N <= 1'b1;
      LOWER_BYTE_SEL_N <= 1'b1;
      MEM_DQ_O         <= '0;
      MEM_DQ_OE        <= 1'b0;
      REQ_READY        <= 1'b0;
    end else begin
      if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      unique case (state_reg)
        S_IDLE: begin
          REQ_READY <= 1'b1;
          if (RETAIN_REQ) begin
            // chip already deselected here, so supply may drop at once [RULE18]
            REQ_READY <= 1'b0;
            state_reg <= S_RETAIN;          // grant raised by the retention process
          end else if (REQ_VALID && REQ_BYTE_EN != 2'b00) begin
            REQ_READY        <= 1'b0;
            // address set together with select, never after it [RULE4] [RULE20] [RULE21]
            MEM_ADDR         <= REQ_ADDR;
            MEM_SEL_N        <= 1'b0;
            UPPER_BYTE_SEL_N <= ~REQ_BYTE_EN[1]; // upper half gate [RULE21]
            LOWER_BYTE_SEL_N <= ~REQ_BYTE_EN[0]; // lower half gate [RULE21]
            MEM_DQ_O         <= REQ_WDATA;
            if (REQ_WRITE) begin
              // strobe low, output gate stays high; wait for float before driving [RULE13]
              MEM_WSTB_N <= 1'b0;
              cnt_reg    <= FLT_CYC;
              state_reg  <= S_WFLOAT;
            end else begin
              // strobe stays high for the whole read [RULE19]
              MEM_OGATE_N <= 1'b0;
              cnt_reg     <= RD_CYC;          // [RULE6] [RULE8] [RULE9]
              state_reg   <= S_READ;
            end
          end
        end
        S_READ: begin
          if (cnt_reg == 8'h00) begin
            // word captured by the response process on this same edge
            MEM_SEL_N        <= 1'b1;        // deselect to standby [RULE17]
            MEM_OGATE_N      <= 1'b1;
            UPPER_BYTE_SEL_N <= 1'b1;
            LOWER_BYTE_SEL_N <= 1'b1;
            cnt_reg          <= FLT_CYC;     // let memory release the bus [RULE10]
            state_reg        <= S_GAP;
          end
        end
        S_WFLOAT: begin
          if (cnt_reg == 8'h00) begin
            MEM_DQ_OE <= 1'b1;               // memory has floated, safe to drive [RULE13]
            // pulse kept long enough for setup and pulse width [RULE3] [RULE5] [RULE15]
            cnt_reg   <= (WP_CYC > WSU_CYC) ? WP_CYC : WSU_CYC;
            state_reg <= S_WPULSE;
          end
        end
        S_WPULSE: begin
          if (cnt_reg == 8'h00) begin
            // strobe rises first and ends the write; address, data held [RULE1] [RULE2]
            MEM_WSTB_N <= 1'b1;
            state_reg  <= S_GAP;
            cnt_reg    <= GAP_CYC;           // spacing between cycles [RULE6]
          end
        end
        S_GAP: begin
          // one cycle after write end: release select and data, zero hold met [RULE3]
          if (MEM_WSTB_N) begin
            MEM_SEL_N        <= 1'b1;        // strobe already high, stays float [RULE14]
            UPPER_BYTE_SEL_N <= 1'b1;
            LOWER_BYTE_SEL_N <= 1'b1;
            MEM_DQ_OE        <= 1'b0;
          end
          if (cnt_reg == 8'h00) begin
            state_reg <= S_IDLE;
          end
        end
        S_RETAIN: begin
          if (!RETAIN_REQ) begin
            // supply restored: wait before next access [RULE18]
            cnt_reg   <= REC_CYC;
            state_reg <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // read response: one-cycle strobe with the word seen at the sample point;
  // the word then stands until the next read replaces it
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
    end else begin
      RSP_VALID <= (state_reg == S_READ) && phase_done(cnt_reg);
      if ((state_reg == S_READ) && phase_done(cnt_reg)) begin
        // worst access time plus synchroniser lag has passed [RULE6]
        RSP_RDATA <= dq_sync_reg;
      end
    end
  end

  // retention grant: raised only from idle, where the chip is already
  // deselected, so the supply may drop at once; dropped when the request
  // falls, and the sequencer then counts out the recovery time
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      RETAIN_OK <= 1'b0;
    end else if ((state_reg == S_IDLE) && RETAIN_REQ) begin
      RETAIN_OK <= 1'b1;                 // [RULE18]
    end else if ((state_reg == S_RETAIN) && !RETAIN_REQ) begin
      RETAIN_OK <= 1'b0;                 // supply back, recovery starts
    end
  end
endmodule

// [bench/sram_host_asserts.sv]
// pin protocol checker for the sram host controller
module sram_host_asserts #(
  parameter int ADDR_W = 19
) (
  input wire logic              CLOCK,       // clock
  input wire logic              RSTN,        // reset, low
  input wire logic [ADDR_W-1:0] MEM_ADDR,    // address pins
  input wire logic              MEM_SEL_N,   // select
  input wire logic              MEM_WSTB_N,  // strobe
  input wire logic              MEM_OGATE_N, // output gate
  input wire logic              MEM_DQ_OE,   // host drives data
  input wire logic              RETAIN_OK    // retention
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // strobe rising ends every write
  sequence wr_end; $rose(MEM_WSTB_N); endsequence
  sequence wr_go; $fell(MEM_WSTB_N); endsequence
  rd_strobe_a: assert property (!MEM_OGATE_N |-> MEM_WSTB_N) else $error("strobe low");
  wr_pulse_a: assert property (wr_go |-> !MEM_WSTB_N[*5]) else $error("short");
  wr_close_a: assert property (wr_end |-> !MEM_SEL_N && MEM_DQ_OE) else $error("end");
  wr_setup_a: assert property (wr_end |-> $past(MEM_DQ_OE, 3)) else $error("setup");
  dq_clash_a: assert property (MEM_DQ_OE |-> MEM_OGATE_N) else $error("clash");
  dq_gap_a: assert property (wr_go |-> !MEM_DQ_OE[*2]) else $error("no float gap");
  // address may not move while selected
  sequence sel_held; !MEM_SEL_N && !$past(MEM_SEL_N); endsequence
  addr_hold_a: assert property (sel_held |-> $stable(MEM_ADDR))
    else $error("address moved");
  sel_span_a: assert property ($fell(MEM_SEL_N) |-> !MEM_SEL_N[*5])
    else $error("cycle");
  retain_sel_a: assert property (RETAIN_OK |-> MEM_SEL_N) else $error("selected");
endmodule
bind sram_host sram_host_asserts #(.ADDR_W(ADDR_W)) u_sram_host_asserts (.*);

// [bench/sram_model.sv]
// behavioural async static memory facing the host
module sram_model (
  input wire logic [18:0] addr,    // word address
  input wire logic        sel_n,   // select
  input wire logic        wstb_n,  // write strobe
  input wire logic        ogate_n, // output gate
  input wire logic        ub_n,    // upper byte
  input wire logic        lb_n,    // lower byte
  input wire logic [15:0] din,     // data from host
  output logic     [15:0] dout     // data to host
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:524287];    // one word per address, unwritten words unknown
  logic [15:0] q = 16'h0;         // pin value
  wire en = !sel_n && !(ub_n && lb_n);  // no wake-up delay
  wire wr = en && !wstb_n;
  wire rd = en && wstb_n && !ogate_n;
  // first enable released closes the write
  always @(negedge wr) begin
    if (!ub_n) mem[addr][15:8] = din[15:8];
    if (!lb_n) mem[addr][7:0] = din[7:0];
  end
  // slowest legal answer; old data stays, unselected bytes show junk
  always @(rd, addr, ub_n, lb_n) begin
    // gate falls with select here, so the 45 ns bound covers the gate delay
    if (rd) q <= #45 {ub_n ? ~q[15:8] : mem[addr][15:8], lb_n ? ~q[7:0] : mem[addr][7:0]};
    // released pins turn to junk after 18 ns, well before any new word at 45 ns
    else q <= #18 ~q;
  end
  assign dout = q;
endmodule

// [bench/tb_top.sv]
// testbench: sram host controller against the memory model
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 0, RSTN = 0, REQ_VALID = 0, REQ_WRITE = 0, RETAIN_REQ = 0; // drives
  logic [18:0] REQ_ADDR = '0, MEM_ADDR;
  logic [15:0] REQ_WDATA = '0, RSP_RDATA, MEM_DQ_O, MEM_DQ_I, mem_out;
  logic [1:0]  REQ_BYTE_EN = '0;
  logic REQ_READY, RSP_VALID, RETAIN_OK, MEM_SEL_N, MEM_WSTB_N, MEM_OGATE_N;
  logic UPPER_BYTE_SEL_N, LOWER_BYTE_SEL_N, MEM_DQ_OE;
  int failures = 0, samples_checked = 0;
  sram_host u_sram_host (.*);
  sram_model u_sram_model (.addr(MEM_ADDR), .sel_n(MEM_SEL_N), .wstb_n(MEM_WSTB_N),
    .ogate_n(MEM_OGATE_N), .ub_n(UPPER_BYTE_SEL_N), .lb_n(LOWER_BYTE_SEL_N),
    .din(MEM_DQ_O), .dout(mem_out));
  // the wire carries whoever drives it
  assign MEM_DQ_I = MEM_DQ_OE ? MEM_DQ_O : mem_out;
  always #5 CLOCK = ~CLOCK;
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait at falling edges; a hang ends the run
  task automatic wait_for(ref logic flag, input logic lvl);
    for (int n = 0; n < 40 && flag !== lvl; n++) @(negedge CLOCK);
    if (flag !== lvl) begin
      failures++;
      end_of_test();
    end
  endtask
  // one access; a read compares only the enabled bytes
  task automatic access(logic wr, logic [18:0] a, logic [15:0] d, logic [1:0] be);
    wait_for(REQ_READY, 1'b1);
    {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_BYTE_EN} = {1'b1, wr, a, d, be};
    @(negedge CLOCK);
    REQ_VALID = 0;
    if (!wr) begin
      wait_for(RSP_VALID, 1'b1);
      check("read", d & {{8{be[1]}}, {8{be[0]}}}, RSP_RDATA & {{8{be[1]}}, {8{be[0]}}});
    end
  endtask
  task automatic t_bytes;
    access(1, 19'h7ffff, 16'ha55a, 2'h3);
    access(1, 19'h00012, 16'h1234, 2'h3);
    access(1, 19'h00012, 16'habcd, 2'h2);
    access(1, 19'h00012, 16'hee77, 2'h1);
    access(0, 19'h00012, 16'hab77, 2'h3);
    access(0, 19'h00012, 16'hab77, 2'h1);
    $display("byte test done");
  endtask
  // no byte enabled: nothing may reach the pins
  task automatic t_refuse;
    wait_for(REQ_READY, 1'b1);
    {REQ_VALID, REQ_BYTE_EN} = {1'b1, 2'h0};
    repeat (8) begin
      @(negedge CLOCK);
      check("idle select", 16'h1, {15'h0, MEM_SEL_N});
    end
    REQ_VALID = 0;
    $display("refuse test done");
  endtask
  // retention, then a read asked at once must wait out recovery
  task automatic t_retain;
    int n;
    RETAIN_REQ = 1;
    wait_for(RETAIN_OK, 1'b1);
    check("retain select", 16'h1, {15'h0, MEM_SEL_N});
    RETAIN_REQ = 0;
    {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_BYTE_EN} = {1'b1, 1'b0, 19'h7ffff, 2'h3};
    for (n = 0; n < 40 && MEM_SEL_N !== 1'b0; n++) @(negedge CLOCK);
    REQ_VALID = 0;
    check("recovery", 16'h1, {15'h0, n >= 5 && n < 40});
    wait_for(RSP_VALID, 1'b1);
    check("kept word", 16'ha55a, RSP_RDATA);
    $display("retain test done");
  endtask
  initial begin
    repeat (3) @(negedge CLOCK);
    RSTN = 1;
    t_bytes();
    t_refuse();
    t_retain();
    end_of_test();
  end
endmodule
